// [design/ubc_pkg.sv]
// constants shared by the baud and enhanced-configuration block
package ubc_pkg;
    // ****************
    // register offsets
    // ****************
    localparam logic [2:0] ADR_DLL = 3'h0;
    localparam logic [2:0] ADR_DLM_IER = 3'h1;
    localparam logic [2:0] ADR_DLD_EFR_ISR = 3'h2;
    localparam logic [2:0] ADR_LCR = 3'h3;
    localparam logic [2:0] ADR_MCR = 3'h4;
    localparam logic [2:0] ADR_STOP2 = 3'h7;
    // ****************
    // keys, reset values and field positions
    // ****************
    localparam logic [7:0] LCR_KEY = 8'hbf;
    localparam logic [7:0] RST_DIV_LOW = 8'h01;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam int LCR_DL_BIT = 7;
    localparam int DLD_IR_BIT = 7;
    localparam int DLD_485_BIT = 6;
    localparam int DLD_OS_HI = 5;
    localparam int DLD_OS_LO = 4;
    localparam int EFR_CTS_BIT = 7;
    localparam int EFR_RTS_BIT = 6;
    localparam int EFR_SPC_BIT = 5;
    localparam int EFR_ENH_BIT = 4;
    localparam int EFR_RX2_BIT = 0;
    localparam int MCR_PRE_BIT = 7;
    localparam int MCR_RTS_BIT = 1;
    localparam int IER_SLEEP_BIT = 4;
    localparam logic [1:0] PRE_LAST = 2'h3;
    // ****************
    // oversampling selections
    // ****************
    localparam logic [1:0] OS_16X = 2'h0;
    localparam logic [1:0] OS_8X = 2'h1;
    localparam logic [4:0] OS_RATIO_16 = 5'h10;
    localparam logic [4:0] OS_RATIO_8 = 5'h08;
    localparam logic [4:0] OS_RATIO_4 = 5'h04;
endpackage

// [design/ubc_baud_if.sv]
// carrier between the register file and the baud generator
`timescale 1ns/1ns
`default_nettype none
interface ubc_baud_if;
    logic [15:0] divisor;
    logic prescale4;
    logic [1:0] os_sel;
    logic sample_tick;
    logic bit_tick;
    modport cfg (output divisor, output prescale4, output os_sel,
                 input sample_tick, input bit_tick);
    modport gen (input divisor, input prescale4, input os_sel,
                 output sample_tick, output bit_tick);
endinterface
`default_nettype wire

// [design/ubc_baud_gen.sv]
// baud generator: prescaler, 16-bit divisor, oversampling counter
`timescale 1ns/1ns
`default_nettype none
module ubc_baud_gen (
    input wire logic clk_i,
    input wire logic nrst_i,
    ubc_baud_if.gen bif
);
    typedef struct packed {
        logic [1:0] pre_cnt;
        logic [15:0] div_cnt;
        logic [3:0] os_cnt;
        logic sample_tick;
        logic bit_tick;
        logic [4:0] chk_gap;
        logic chk_clean;
    } ubc_gen_t;

    ubc_gen_t gen_reg;
    ubc_gen_t gen_next;

    function automatic logic [4:0] os_ratio(input logic [1:0] sel);
        case (sel)
            ubc_pkg::OS_16X: os_ratio = ubc_pkg::OS_RATIO_16;
            ubc_pkg::OS_8X: os_ratio = ubc_pkg::OS_RATIO_8;
            default: os_ratio = ubc_pkg::OS_RATIO_4;
        endcase
    endfunction

    logic [4:0] ratio;
    logic pre_done;
    logic x16_one;
    assign ratio = os_ratio(bif.os_sel);
    assign x16_one = bif.divisor == 16'h0001 && !bif.prescale4 && bif.os_sel == ubc_pkg::OS_16X;
    assign pre_done = !bif.prescale4 || (gen_reg.pre_cnt == ubc_pkg::PRE_LAST);

    // rate = ref / (divisor * prescale * oversampling); divisor 0 halts
    always_comb begin
        gen_next = gen_reg;
        gen_next.sample_tick = 1'b0;
        gen_next.bit_tick = 1'b0;
        if (bif.divisor != 16'h0000) begin
            gen_next.pre_cnt = pre_done ? 2'h0 : gen_reg.pre_cnt + 2'h1; // see [R8]
            if (pre_done) begin
                if (gen_reg.div_cnt >= bif.divisor - 16'h0001) begin
                    gen_next.div_cnt = 16'h0000;
                    gen_next.sample_tick = 1'b1;
                    if ({1'b0, gen_reg.os_cnt} >= ratio - 5'h01) begin // see [R7]
                        gen_next.os_cnt = 4'h0;
                        gen_next.bit_tick = 1'b1;
                    end else begin
                        gen_next.os_cnt = gen_reg.os_cnt + 4'h1;
                    end
                end else begin
                    gen_next.div_cnt = gen_reg.div_cnt + 16'h0001;
                end
            end
        end else begin
            gen_next.pre_cnt = 2'h0;
            gen_next.div_cnt = 16'h0000;
            gen_next.os_cnt = 4'h0;
        end
        // cycles since last bit tick, clean while divisor one at 16x with prescale off held
        if (gen_reg.bit_tick) begin
            gen_next.chk_gap = 5'h00;
            gen_next.chk_clean = x16_one;
        end else begin
            gen_next.chk_gap = (gen_reg.chk_gap == 5'h1f) ? 5'h1f : gen_reg.chk_gap + 5'h01;
            gen_next.chk_clean = gen_reg.chk_clean && x16_one;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            gen_reg <= '0;
        end else begin
            gen_reg <= gen_next;
        end
    end

    assign bif.sample_tick = gen_reg.sample_tick;
    assign bif.bit_tick = gen_reg.bit_tick;

    // ****************
    // checks
    // ****************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    a_bit_needs_sample: assert property ( // see [R8]
        gen_reg.bit_tick |-> gen_reg.sample_tick && gen_reg.os_cnt == 4'h0)
        else $error("bit tick without wrapped sample count");
    a_div_one_x16: assert property ( // see [R7]
        gen_reg.bit_tick && gen_reg.chk_clean && x16_one |-> gen_reg.chk_gap == 5'h0f)
        else $error("16x bit period at divisor one is not 16 cycles");
    a_zero_div_silent: assert property ( // see [R8]
        bif.divisor == 16'h0000 ##1 bif.divisor == 16'h0000 |-> !gen_reg.sample_tick)
        else $error("sample tick with zero divisor");
endmodule
`default_nettype wire

// [design/ubc_top.sv]
// baud rate and enhanced feature control for one serial channel
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// [R1] divisor high byte reachable when divisor latch open
// [R2] high byte resets to zero on power-on only
// [R3] low byte resets to one, power-on only
// [R4] mode register needs enhanced bit and latch bit
// [R5] mode bit 7 selects infrared coding
// [R6] mode bit 6 enables automatic RS-485 direction
// [R7] mode bits 5:4 select 16x, 8x, 4x
// [R8] rate = ref / (divisor*prescale*oversampling)
// [R9] feature bit 7 holds transmit on CTS
// [R10] feature bit 6 drives RTS from buffer level
// [R11] special match stored and flags status bit 4
// [R12] compared stop char two dropped, both flags; code sets the special flag only with feature bit 5
// [R13] enhanced writes need feature bit 4
// [R14] sleep only allowed with feature bit 4
// [R15] upper select 00 means no transmit flow
// [R16] upper select 10, 01, 11 pick pairs
// [R17] lower select 00 off, 10 first, 01 second
module ubc_top (
    input wire logic CLK_I,
    input wire logic NRST_I,
    input wire logic [2:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic CTS_N_I,
    input wire logic RX_VALID_I,
    input wire logic [7:0] RX_DATA_I,
    input wire logic RX_HALT_I,
    output logic [7:0] RDATA_O,
    output logic SAMPLE_TICK_O,
    output logic BIT_TICK_O,
    output logic IR_MODE_O,
    output logic RS485_AUTO_O,
    output logic TX_HOLD_O,
    output logic RTS_N_O,
    output logic SLEEP_O,
    output logic RX_STORE_O,
    output logic [7:0] RX_STORE_DATA_O,
    output logic SPECIAL_INT_O,
    output logic STOP_INT_O,
    output logic [1:0] TX_SWFC_O,
    output logic [1:0] RX_SWFC_O
);
    typedef struct packed {
        logic [7:0] dll;
        logic [7:0] divisor_high_byte;
        logic [7:0] divisor_mode_control;
        logic [7:0] enhanced_feature_control;
        logic [7:0] line_control_reg;
        logic [7:0] modem_control_reg;
        logic [7:0] interrupt_enable_reg;
        logic [1:0] fcr_enh;
        logic [7:0] stop2;
        logic [7:0] rdata;
        logic cts_meta;
        logic cts_sync;
        logic tx_hold;
        logic rts_n;
        logic sleep;
        logic rx_store;
        logic [7:0] rx_store_data;
        logic special;
        logic stop;
    } ubc_state_t;

    ubc_state_t st_reg;
    ubc_state_t st_next;

    ubc_baud_if bif ();

    ubc_baud_gen u_gen (
        .clk_i(CLK_I),
        .nrst_i(NRST_I),
        .bif(bif)
    );

    assign bif.divisor = {st_reg.divisor_high_byte, st_reg.dll}; // see [R8]
    assign bif.prescale4 = st_reg.modem_control_reg[ubc_pkg::MCR_PRE_BIT]; // see [R8]
    assign bif.os_sel = st_reg.divisor_mode_control[ubc_pkg::DLD_OS_HI:ubc_pkg::DLD_OS_LO]; // see [R7]

    // ****************
    // access windows
    // ****************
    logic key_open;
    logic dl_open;
    logic enh;
    logic cmp2;
    logic stop_hit;
    logic isr_rd;
    assign key_open = (st_reg.line_control_reg == ubc_pkg::LCR_KEY);
    assign dl_open = st_reg.line_control_reg[ubc_pkg::LCR_DL_BIT] && !key_open; // see [R1]
    assign enh = st_reg.enhanced_feature_control[ubc_pkg::EFR_ENH_BIT];
    assign cmp2 = st_reg.enhanced_feature_control[ubc_pkg::EFR_RX2_BIT];
    assign stop_hit = RX_VALID_I && (RX_DATA_I == st_reg.stop2);
    assign isr_rd = RD_I && !st_reg.line_control_reg[ubc_pkg::LCR_DL_BIT]
                    && ADDR_I == ubc_pkg::ADR_DLD_EFR_ISR;

    always_comb begin
        st_next = st_reg;
        st_next.rx_store = 1'b0;
        // ****************
        // register writes
        // ****************
        if (WR_I) begin
            case (ADDR_I)
                ubc_pkg::ADR_DLL: begin
                    if (dl_open) st_next.dll = WDATA_I; // see [R3]
                end
                ubc_pkg::ADR_DLM_IER: begin
                    if (dl_open) begin
                        st_next.divisor_high_byte = WDATA_I; // see [R1]
                    end else if (!st_reg.line_control_reg[ubc_pkg::LCR_DL_BIT]) begin
                        st_next.interrupt_enable_reg = enh ? WDATA_I : {st_reg.interrupt_enable_reg[7:4], WDATA_I[3:0]}; // see [R13]
                    end
                end
                ubc_pkg::ADR_DLD_EFR_ISR: begin
                    if (key_open) begin
                        st_next.enhanced_feature_control = WDATA_I;
                    end else if (dl_open) begin
                        if (enh) st_next.divisor_mode_control = WDATA_I; // see [R4]
                    end else if (enh) begin
                        st_next.fcr_enh = WDATA_I[5:4]; // see [R13]
                    end
                end
                ubc_pkg::ADR_LCR: st_next.line_control_reg = WDATA_I;
                ubc_pkg::ADR_MCR: begin
                    if (!st_reg.line_control_reg[ubc_pkg::LCR_DL_BIT]) begin
                        st_next.modem_control_reg = enh ? WDATA_I : {st_reg.modem_control_reg[7:5], WDATA_I[4:0]}; // see [R13]
                    end
                end
                ubc_pkg::ADR_STOP2: begin
                    if (key_open) st_next.stop2 = WDATA_I;
                end
                default: ;
            endcase
        end
        // ****************
        // register reads, unmapped reads return zero
        // ****************
        st_next.rdata = 8'h00;
        if (RD_I) begin
            case (ADDR_I)
                ubc_pkg::ADR_DLL: if (dl_open) st_next.rdata = st_reg.dll;
                ubc_pkg::ADR_DLM_IER: begin
                    if (dl_open) st_next.rdata = st_reg.divisor_high_byte;
                    else if (!st_reg.line_control_reg[ubc_pkg::LCR_DL_BIT]) st_next.rdata = st_reg.interrupt_enable_reg;
                end
                ubc_pkg::ADR_DLD_EFR_ISR: begin
                    if (key_open) begin
                        st_next.rdata = st_reg.enhanced_feature_control;
                    end else if (dl_open) begin
                        if (enh) st_next.rdata = st_reg.divisor_mode_control; // see [R4]
                    end else begin
                        st_next.rdata = {3'h0, st_reg.special | st_reg.stop, 3'h0,
                                         !(st_reg.special | st_reg.stop)}; // see [R11]
                    end
                end
                ubc_pkg::ADR_LCR: st_next.rdata = st_reg.line_control_reg;
                ubc_pkg::ADR_MCR: begin
                    if (!st_reg.line_control_reg[ubc_pkg::LCR_DL_BIT]) st_next.rdata = st_reg.modem_control_reg;
                end
                ubc_pkg::ADR_STOP2: if (key_open) st_next.rdata = st_reg.stop2;
                default: ;
            endcase
        end
        // ****************
        // receive character screening, set wins over read clear
        // ****************
        st_next.special = st_reg.special && !isr_rd;
        st_next.stop = st_reg.stop && !isr_rd;
        if (RX_VALID_I) begin
            if (stop_hit && cmp2) begin
                st_next.stop = 1'b1; // see [R12]
                if (st_reg.enhanced_feature_control[ubc_pkg::EFR_SPC_BIT]) st_next.special = 1'b1; // see [R12]
            end else begin
                st_next.rx_store = 1'b1; // see [R11]
                st_next.rx_store_data = RX_DATA_I;
                if (stop_hit && st_reg.enhanced_feature_control[ubc_pkg::EFR_SPC_BIT]) st_next.special = 1'b1; // see [R11]
            end
        end
        // ****************
        // flow control and power
        // ****************
        st_next.cts_meta = CTS_N_I;
        st_next.cts_sync = st_reg.cts_meta;
        st_next.tx_hold = st_reg.enhanced_feature_control[ubc_pkg::EFR_CTS_BIT] && st_reg.cts_sync; // see [R9]
        st_next.rts_n = st_reg.enhanced_feature_control[ubc_pkg::EFR_RTS_BIT] ? RX_HALT_I // see [R10]
                        : !st_reg.modem_control_reg[ubc_pkg::MCR_RTS_BIT];
        st_next.sleep = enh && st_reg.interrupt_enable_reg[ubc_pkg::IER_SLEEP_BIT]; // see [R14]
    end

    // only power-on reset exists, so divisor bytes take their reset values on it alone
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            st_reg <= '0;
            st_reg.dll <= ubc_pkg::RST_DIV_LOW; // see [R3]
            st_reg.divisor_high_byte <= ubc_pkg::RST_ZERO; // see [R2]
            st_reg.divisor_mode_control <= ubc_pkg::RST_ZERO; // see [R4]
            st_reg.cts_meta <= 1'b1;
            st_reg.cts_sync <= 1'b1;
            st_reg.rts_n <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign RDATA_O = st_reg.rdata;
    assign SAMPLE_TICK_O = bif.sample_tick;
    assign BIT_TICK_O = bif.bit_tick;
    assign IR_MODE_O = st_reg.divisor_mode_control[ubc_pkg::DLD_IR_BIT]; // see [R5]
    assign RS485_AUTO_O = st_reg.divisor_mode_control[ubc_pkg::DLD_485_BIT]; // see [R6]
    assign TX_HOLD_O = st_reg.tx_hold;
    assign RTS_N_O = st_reg.rts_n;
    assign SLEEP_O = st_reg.sleep;
    assign RX_STORE_O = st_reg.rx_store;
    assign RX_STORE_DATA_O = st_reg.rx_store_data;
    assign SPECIAL_INT_O = st_reg.special;
    assign STOP_INT_O = st_reg.stop;
    assign TX_SWFC_O = st_reg.enhanced_feature_control[3:2]; // see [R15] see [R16]
    assign RX_SWFC_O = st_reg.enhanced_feature_control[1:0]; // see [R17]

    // ****************
    // checks
    // ****************
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!NRST_I);

    sequence s_key_write;
        WR_I && ADDR_I == ubc_pkg::ADR_DLM_IER && key_open;
    endsequence
    a_dlm_locked: assert property (s_key_write |=> $stable(st_reg.divisor_high_byte)) // see [R1]
        else $error("divisor high byte written under key");
    a_dld_gate: assert property ( // see [R4]
        WR_I && ADDR_I == ubc_pkg::ADR_DLD_EFR_ISR && dl_open && !enh |=> $stable(st_reg.divisor_mode_control))
        else $error("mode register written without enhanced bit");
    a_mcr_top_gate: assert property ( // see [R13]
        WR_I && ADDR_I == ubc_pkg::ADR_MCR && !enh |=> $stable(st_reg.modem_control_reg[7:5]))
        else $error("modem control top bits written without enhanced bit");
    a_sleep_gate: assert property (SLEEP_O |-> $past(enh)) // see [R14]
        else $error("sleep entered without enhanced bit");
    a_stop_dropped: assert property ( // see [R12]
        stop_hit && cmp2 |=> !RX_STORE_O && STOP_INT_O)
        else $error("compared stop character reached the buffer");
    a_special_kept: assert property ( // see [R11]
        stop_hit && !cmp2 && st_reg.enhanced_feature_control[ubc_pkg::EFR_SPC_BIT] |=>
        RX_STORE_O && SPECIAL_INT_O && RX_STORE_DATA_O == $past(RX_DATA_I))
        else $error("special character not stored and flagged");
    a_cts_hold: assert property ( // see [R9]
        (st_reg.enhanced_feature_control[ubc_pkg::EFR_CTS_BIT] && CTS_N_I) [*4] |-> TX_HOLD_O)
        else $error("transmit not held with CTS deasserted");
    a_rts_follow: assert property ( // see [R10]
        st_reg.enhanced_feature_control[ubc_pkg::EFR_RTS_BIT] ##1 st_reg.enhanced_feature_control[ubc_pkg::EFR_RTS_BIT] |->
        RTS_N_O == $past(RX_HALT_I))
        else $error("RTS does not follow buffer level");
endmodule
`default_nettype wire

// [tb/ubc_line_partner.sv]
// model of the remote serial device feeding the receive screen and cts pin
`timescale 1ns/1ns
`default_nettype none
module ubc_line_partner (
    input wire logic clk_i,
    output logic cts_n_o,
    output logic rx_valid_o,
    output logic [7:0] rx_data_o
);
    // ****************
    // idle line state
    // ****************
    initial begin
        cts_n_o = 1'b0;
        rx_valid_o = 1'b0;
        rx_data_o = 8'h00;
    end
    // ****************
    // line actions
    // ****************
    task automatic set_cts(input logic v);
        @(posedge clk_i);
        cts_n_o <= v;
    endtask
    // data is scrambled once the strobe drops
    task automatic send(input logic [7:0] b);
        @(posedge clk_i);
        rx_valid_o <= 1'b1;
        rx_data_o <= b;
        @(posedge clk_i);
        rx_valid_o <= 1'b0;
        rx_data_o <= ~b;
    endtask
endmodule
`default_nettype wire

// [tb/ubc_top_test.sv]
// self-checking bench for the baud and enhanced configuration block
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp, msg) begin comparisons++; if ((got) !== (exp)) begin \
    errors++; $display("CHECK FAILED t=%0t %s", $time, msg); end end
module ubc_top_test;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic rx_halt = 1'b0;
    logic cts_n;
    logic rx_valid;
    logic [7:0] rx_data;
    logic [7:0] rdata;
    logic sample_tick;
    logic bit_tick;
    logic ir_mode;
    logic rs485_auto;
    logic tx_hold;
    logic rts_n;
    logic sleep;
    logic rx_store;
    logic [7:0] rx_store_data;
    logic special_int;
    logic stop_int;
    logic [1:0] tx_swfc;
    logic [1:0] rx_swfc;
    int errors = 0;
    int comparisons = 0;
    int cycles = 0;
    int bt_exp[4] = '{32, 16, 8, 8};
    logic [7:0] code;

    always #50 clk = ~clk;

    ubc_top dut (
        .CLK_I(clk), .NRST_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr_en),
        .RD_I(rd_en), .CTS_N_I(cts_n), .RX_VALID_I(rx_valid), .RX_DATA_I(rx_data),
        .RX_HALT_I(rx_halt), .RDATA_O(rdata), .SAMPLE_TICK_O(sample_tick),
        .BIT_TICK_O(bit_tick), .IR_MODE_O(ir_mode), .RS485_AUTO_O(rs485_auto),
        .TX_HOLD_O(tx_hold), .RTS_N_O(rts_n), .SLEEP_O(sleep), .RX_STORE_O(rx_store),
        .RX_STORE_DATA_O(rx_store_data), .SPECIAL_INT_O(special_int),
        .STOP_INT_O(stop_int), .TX_SWFC_O(tx_swfc), .RX_SWFC_O(rx_swfc)
    );

    ubc_line_partner partner (
        .clk_i(clk),
        .cts_n_o(cts_n),
        .rx_valid_o(rx_valid),
        .rx_data_o(rx_data)
    );

    // ****************
    // verdict and hang guard
    // ****************
    task automatic wrap_up;
        if (errors == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            wrap_up();
        end
    end

    // ****************
    // register port tasks
    // ****************
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, input logic [7:0] exp, input string msg);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        `CHK(rdata, exp, msg)
    endtask

    task automatic settle;
        repeat (4) @(posedge clk);
        #1;
    endtask

    // third interval is a full period after any config change
    task automatic period(input logic bt, input int exp, input string msg);
        int n;
        int k;
        n = 0;
        for (k = 0; k < 3; k++) begin
            n = 0;
            do begin
                @(posedge clk);
                #1;
                n++;
            end while (((bt ? bit_tick : sample_tick) !== 1'b1) && n < 1000);
        end
        `CHK(n, exp, msg)
    endtask

    task automatic screen(input logic [7:0] b, input logic st, input logic sp, input logic sc);
        partner.send(b);
        #1;
        `CHK({rx_store, stop_int, special_int}, {st, sp, sc}, "screen result")
    endtask

    // ****************
    // main sequence
    // ****************
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        `CHK(rts_n, 1'b1, "rts idle after reset")
        wr(3'h3, 8'h80);
        rd(3'h0, 8'h01, "div low reset");
        rd(3'h1, 8'h00, "div high reset");
        wr(3'h1, 8'h12);
        rd(3'h1, 8'h12, "div high rw");
        wr(3'h2, 8'hff);
        rd(3'h2, 8'h00, "mode locked");
        wr(3'h3, 8'hbf);
        wr(3'h1, 8'h55);
        rd(3'h1, 8'h00, "div high hidden by key");
        wr(3'h2, 8'h10);
        wr(3'h3, 8'h80);
        rd(3'h1, 8'h12, "div high kept under key");
        wr(3'h2, 8'hc0);
        rd(3'h2, 8'hc0, "mode rw");
        `CHK({ir_mode, rs485_auto}, 2'h3, "mode outputs on")
        wr(3'h2, 8'h00);
        settle();
        `CHK({ir_mode, rs485_auto}, 2'h0, "mode outputs off")
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        wr(3'h3, 8'h80);
        rd(3'h1, 8'h00, "div high cleared");
        rd(3'h0, 8'h01, "div low cleared");
        period(1'b1, 16, "bit period at divisor one");
        // baud rates
        wr(3'h0, 8'h02);
        period(1'b0, 2, "sample period");
        period(1'b1, 32, "bit period 16x");
        wr(3'h3, 8'hbf);
        wr(3'h2, 8'h10);
        wr(3'h3, 8'h80);
        for (int i = 0; i < 4; i++) begin
            wr(3'h2, {2'b00, i[1:0], 4'h0});
            period(1'b1, bt_exp[i], "bit period by ratio");
        end
        wr(3'h2, 8'h00);
        wr(3'h3, 8'h00);
        wr(3'h4, 8'h80);
        period(1'b0, 8, "sample with prescale");
        period(1'b1, 128, "bit with prescale");
        rd(3'h4, 8'h80, "prescale stored");
        wr(3'h3, 8'h80);
        wr(3'h0, 8'h00);
        period(1'b0, 1000, "zero divisor idle");
        wr(3'h0, 8'h02);
        // enhanced write gate and sleep
        wr(3'h3, 8'hbf);
        wr(3'h2, 8'h00);
        wr(3'h3, 8'h00);
        wr(3'h4, 8'he2);
        rd(3'h4, 8'h82, "mcr high locked");
        wr(3'h1, 8'h1f);
        rd(3'h1, 8'h0f, "ier high locked");
        `CHK(sleep, 1'b0, "sleep refused")
        `CHK(rts_n, 1'b0, "manual rts")
        wr(3'h3, 8'hbf);
        wr(3'h2, 8'h10);
        wr(3'h3, 8'h00);
        wr(3'h1, 8'h10);
        rd(3'h1, 8'h10, "ier high open");
        settle();
        `CHK(sleep, 1'b1, "sleep granted")
        @(posedge clk);
        rx_halt <= 1'b1;
        settle();
        `CHK(rts_n, 1'b0, "halt ignored when manual")
        wr(3'h3, 8'hbf);
        wr(3'h2, 8'hd0);
        settle();
        `CHK(rts_n, 1'b1, "auto rts halts")
        @(posedge clk);
        rx_halt <= 1'b0;
        settle();
        `CHK(rts_n, 1'b0, "auto rts resumes")
        partner.set_cts(1'b1);
        settle();
        `CHK(tx_hold, 1'b1, "cts holds tx")
        partner.set_cts(1'b0);
        settle();
        `CHK(tx_hold, 1'b0, "cts releases tx")
        wr(3'h2, 8'h10);
        partner.set_cts(1'b1);
        settle();
        `CHK(tx_hold, 1'b0, "auto cts off")
        wr(3'h2, 8'h00);
        settle();
        `CHK(sleep, 1'b0, "sleep dropped")
        // special and stop character screening
        wr(3'h7, 8'h5a);
        wr(3'h2, 8'h20);
        screen(8'h5a, 1'b1, 1'b0, 1'b1);
        `CHK(rx_store_data, 8'h5a, "stored special byte")
        wr(3'h3, 8'h00);
        rd(3'h2, 8'h10, "status flag set");
        rd(3'h2, 8'h01, "status flag cleared");
        wr(3'h3, 8'hbf);
        wr(3'h2, 8'h21);
        screen(8'h5a, 1'b0, 1'b1, 1'b1);
        screen(8'h33, 1'b1, 1'b1, 1'b1);
        `CHK(rx_store_data, 8'h33, "ordinary byte stored")
        wr(3'h3, 8'h00);
        rd(3'h2, 8'h10, "both flags read");
        wr(3'h3, 8'hbf);
        wr(3'h2, 8'h01);
        screen(8'h5a, 1'b0, 1'b1, 1'b0);
        // flow control select field
        for (int i = 0; i < 16; i++) begin
            code = 8'(i);
            wr(3'h2, code);
            settle();
            `CHK(tx_swfc, code[3:2], "tx select")
            `CHK(rx_swfc, code[1:0], "rx select")
        end
        wrap_up();
    end
endmodule
`default_nettype wire
